// ### logic/rcd_pkg.sv
package rcd_pkg;
  localparam int FRAME_BITS = 16;
  localparam int DATA_W = 10;
  localparam int CMD_W = 4;
  localparam int CMD_LSB = 10;
  localparam int FUSE_LOCS = 50;
  localparam int ADDR_W = 6;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_RD_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE = 4'h3;
  localparam logic [3:0] CMD_RELOAD = 4'h4;
  localparam logic [3:0] CMD_RD_FUSE = 4'h5;
  localparam logic [3:0] CMD_RD_LAST = 4'h6;
  localparam logic [3:0] CMD_WR_CTRL = 4'h7;
  localparam logic [3:0] CMD_RD_CTRL = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h9;
  localparam int CTRL_PROG_EN = 0;
  localparam int CTRL_UNLOCK = 1;
  localparam int CTRL_CAL_BYP = 2;
  localparam int CTRL_SUCCESS = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
  localparam logic [5:0] FIRST_LOC = 6'h01;
  localparam logic [5:0] LAST_LOC = 6'h32;
  localparam int CLK_MHZ = 125;
  localparam int STORE_MS = 350;
  localparam int STORE_CYCLES = STORE_MS * 1000 * CLK_MHZ;
endpackage : rcd_pkg

// ### logic/rcd_frame_if.sv
`timescale 1ns/1ns
interface rcd_frame_if;
  logic done;
  logic [15:0] word;
  logic [15:0] load_word;
  logic load;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_low;
  modport rx (output done, output word, output sclk_rise, output sclk_fall, output sel_low);
  modport core (input done, input word, input sclk_rise, input sclk_fall, input sel_low,
    output load_word, output load);
  modport tx (input load_word, input load, input sclk_rise, input sclk_fall, input sel_low);
endinterface : rcd_frame_if

// ### logic/rcd_shift_rx.sv
`timescale 1ns/1ns
module rcd_shift_rx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic lock,
  rcd_frame_if.rx fr
);
  logic [2:0] s0_reg, s1_reg;
  logic sclk_d_reg, sync_d_reg;
  logic [15:0] shift_reg;
  logic [3:0] cnt_reg;
  logic whole_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_reg <= 3'h1;
      s1_reg <= 3'h1;
      sclk_d_reg <= 1'b0;
      sync_d_reg <= 1'b1;
    end else begin
      s0_reg <= {sclk, din, sync_n};
      s1_reg <= s0_reg;
      sclk_d_reg <= s1_reg[2];
      sync_d_reg <= s1_reg[0];
    end
  end

  assign fr.sclk_rise = s1_reg[2] & ~sclk_d_reg;
  assign fr.sclk_fall = ~s1_reg[2] & sclk_d_reg;
  assign fr.sel_low = ~s1_reg[0];

  // shifter frozen while a fuse store runs [R16]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      whole_reg <= 1'b0;
    end else if (!lock) begin
      if (fr.sel_low && fr.sclk_fall) begin
        shift_reg <= {shift_reg[14:0], s1_reg[1]}; // [R1]
        cnt_reg <= cnt_reg + 4'h1;
        whole_reg <= (cnt_reg == 4'hF);
      end else if (!fr.sel_low) begin
        cnt_reg <= 4'h0;
        whole_reg <= 1'b0;
      end
    end
  end

  // only a frame of a whole multiple of 16 clocks is decoded [R2]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr.done <= 1'b0;
      fr.word <= 16'h0000;
    end else begin
      fr.done <= s1_reg[0] & ~sync_d_reg & whole_reg & (cnt_reg == 4'h0) & ~lock;
      fr.word <= shift_reg;
    end
  end
endmodule : rcd_shift_rx

// ### logic/rcd_shift_tx.sv
`timescale 1ns/1ns
module rcd_shift_tx (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic serial_out_o,
  rcd_frame_if.tx fr
);
  logic [15:0] out_reg;

  // next frame shifts out the prepared word, msb first on the rising edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 16'h0000;
      serial_out_o <= 1'b0;
    end else begin
      if (fr.load) begin
        out_reg <= fr.load_word;
      end else if (fr.sel_low && fr.sclk_rise) begin
        serial_out_o <= out_reg[15];
        out_reg <= {out_reg[14:0], 1'b0};
      end
    end
  end
endmodule : rcd_shift_tx

// ### logic/rcd_core.sv
`timescale 1ns/1ns
// Contract
// R1: frame is 16 bits msb first: two zeros, four-bit command, ten-bit data.
// R2: frame select held low for multiples of 16 clocks; decode on its rise.
// R3: codes 0-3: nop, write wiper, prepare wiper readback, store to fuse.
// R4: code 4 reloads wiper from last programmed location, data ignored.
// R5: code 5 reads fuse location from data bits 5..0 next frame.
// R6: code 6 prepares last programmed address for next frame readback.
// R7: last address returned in the six low bits of the word.
// R8: code 7 writes data bits 2..0 into the control bits.
// R9: code 8 prepares control register readback for next frame.
// R10: code 9 data bit 0 enters or leaves shutdown.
// R11: control reads as ten bits: zeros, success, bypass, unlock, program enable.
// R12: wiper register drives wiper position directly; zero is terminal A end.
// R13: wiper may be rewritten without limit by code 1.
// R14: first store goes to location 1, then increments per store.
// R15: locations 1 to 50 hold values; at most 50 stores; 0 reserved.
// R16: store lasts about 350 ms; shift register locked meanwhile.
// R17: success flag set on completed store; host polls it.
// R18: without a programmed location, wiper presets to midscale at power-up.
// R19: unlock bit clears at power-up, blocking wiper writes and stores.
// R20: while locked, only the reload changes the wiper.
// R21: host sets the unlock bit before updating the wiper.
// R22: program enable resets to 0 and must be 1 for a store.
// R23: codes 10 to 15 are no operation.
// R24: midscale is 0x200 for the ten-bit wiper.
module rcd_core #(
  parameter int STORE_CYCLES = rcd_pkg::STORE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  output logic serial_out,
  output logic [9:0] wiper_position,
  output logic shutdown,
  output logic calibration_bypass,
  output logic fuse_busy
);
  typedef enum logic [1:0] {
    RCD_IDLE = 2'b01,
    RCD_BURN = 2'b10
  } rcd_state_e;

  rcd_frame_if fr ();

  logic [9:0] wiper_setting_register;
  logic [9:0] fuse_store [1:rcd_pkg::FUSE_LOCS];
  logic [5:0] last_loc_reg;
  logic [3:0] ctrl_reg;
  logic shut_reg;
  rcd_state_e state_reg;
  logic [31:0] burn_cnt_reg;
  logic [3:0] cmd;
  logic [9:0] data;
  logic [9:0] last_value;
  logic [9:0] fuse_rd;
  logic serial_bit;
  logic lock;

  assign lock = (state_reg == RCD_BURN); // [R16]

  rcd_shift_rx u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sync_n(sync_n),
    .sclk(sclk),
    .din(din),
    .lock(lock),
    .fr(fr)
  );

  rcd_shift_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .serial_out_o(serial_bit),
    .fr(fr)
  );

  // ****************************************
  // command decode
  // ****************************************
  assign cmd = fr.word[rcd_pkg::CMD_LSB +: rcd_pkg::CMD_W]; // [R1]
  assign data = fr.word[rcd_pkg::DATA_W-1:0];

  // no programmed location means midscale [R18] [R24]
  assign last_value = (last_loc_reg == 6'h00) ? rcd_pkg::WIPER_MIDSCALE : fuse_store[last_loc_reg];

  // reserved location 0 and out-of-range reads return zero [R15]
  assign fuse_rd = (data[5:0] >= rcd_pkg::FIRST_LOC && data[5:0] <= rcd_pkg::LAST_LOC) ?
    fuse_store[data[5:0]] : 10'h000;

  // wiper register; power-up preset is the WIPER_MIDSCALE constant, not read from the store [R18] [R19]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_setting_register <= rcd_pkg::WIPER_MIDSCALE;
    end else if (fr.done) begin
      if (cmd == rcd_pkg::CMD_WR_WIPER && ctrl_reg[rcd_pkg::CTRL_UNLOCK]) begin
        wiper_setting_register <= data; // [R3] [R13] [R20]
      end else if (cmd == rcd_pkg::CMD_RELOAD) begin
        wiper_setting_register <= last_value; // [R4] [R20]
      end
    end
  end

  // ****************************************
  // control bits and shutdown
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rcd_pkg::CTRL_RESET; // [R19] [R22]
      shut_reg <= 1'b0;
    end else begin
      if (state_reg == RCD_BURN && burn_cnt_reg == 32'd1) begin
        ctrl_reg[rcd_pkg::CTRL_SUCCESS] <= 1'b1; // [R17]
      end else if (fr.done && cmd == rcd_pkg::CMD_STORE) begin
        ctrl_reg[rcd_pkg::CTRL_SUCCESS] <= 1'b0;
      end
      if (fr.done && cmd == rcd_pkg::CMD_WR_CTRL) begin
        ctrl_reg[2:0] <= data[2:0]; // [R8]
      end
      if (fr.done && cmd == rcd_pkg::CMD_SHUTDOWN) begin
        shut_reg <= data[0]; // [R10]
      end else if (fr.done && cmd == rcd_pkg::CMD_RELOAD) begin
        shut_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // fuse store sequencing
  // ****************************************
  // a store needs unlock and program enable and a free location [R22] [R15]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RCD_IDLE;
      burn_cnt_reg <= 32'd0;
      last_loc_reg <= 6'h00;
    end else begin
      case (state_reg)
        RCD_IDLE: begin
          if (fr.done && cmd == rcd_pkg::CMD_STORE && ctrl_reg[rcd_pkg::CTRL_PROG_EN] &&
              ctrl_reg[rcd_pkg::CTRL_UNLOCK] && last_loc_reg < rcd_pkg::LAST_LOC) begin
            state_reg <= RCD_BURN; // [R3]
            burn_cnt_reg <= 32'(STORE_CYCLES);
            last_loc_reg <= last_loc_reg + 6'h01; // [R14]
          end
        end
        RCD_BURN: begin
          burn_cnt_reg <= burn_cnt_reg - 32'd1;
          if (burn_cnt_reg == 32'd1) state_reg <= RCD_IDLE; // [R16]
        end
        default: state_reg <= RCD_IDLE;
      endcase
    end
  end

  // fuse cells modelled as flip-flops written once each
  generate
    for (genvar i = 1; i <= rcd_pkg::FUSE_LOCS; i++) begin : g_fuse
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          fuse_store[i] <= 10'h000;
        end else if (state_reg == RCD_IDLE && fr.done && cmd == rcd_pkg::CMD_STORE &&
                     ctrl_reg[rcd_pkg::CTRL_PROG_EN] && ctrl_reg[rcd_pkg::CTRL_UNLOCK] &&
                     last_loc_reg == 6'(i - 1)) begin
          fuse_store[i] <= wiper_setting_register; // [R14]
        end
      end
    end
  endgenerate

  // ****************************************
  // readback preparation
  // ****************************************
  // every decoded frame reloads the output word; nop sends zeros
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr.load <= 1'b0;
      fr.load_word <= 16'h0000;
    end else begin
      fr.load <= fr.done;
      if (fr.done) begin
        case (cmd)
          rcd_pkg::CMD_RD_WIPER: fr.load_word <= {6'h00, wiper_setting_register}; // [R3]
          rcd_pkg::CMD_RD_FUSE: fr.load_word <= {6'h00, fuse_rd}; // [R5]
          rcd_pkg::CMD_RD_LAST: fr.load_word <= {10'h000, last_loc_reg}; // [R6] [R7]
          rcd_pkg::CMD_RD_CTRL: fr.load_word <= {12'h000, ctrl_reg}; // [R9] [R11]
          default: fr.load_word <= 16'h0000; // [R23]
        endcase
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      wiper_position <= rcd_pkg::WIPER_MIDSCALE;
      shutdown <= 1'b0;
      calibration_bypass <= 1'b0;
      fuse_busy <= 1'b0;
    end else begin
      serial_out <= serial_bit;
      wiper_position <= wiper_setting_register; // [R12]
      shutdown <= shut_reg;
      calibration_bypass <= ctrl_reg[rcd_pkg::CTRL_CAL_BYP];
      fuse_busy <= lock;
    end
  end
endmodule : rcd_core

// ### tb/rcd_checker.sv
`timescale 1ns/1ns
module rcd_checker #(
  parameter int STORE_CYCLES = 400
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic [9:0] wiper_position,
  input wire logic shutdown,
  input wire logic calibration_bypass,
  input wire logic fuse_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] hi_cnt;
  int busy_cnt;
  logic in_win;
  // cycles since frame select went high; effects must land in this short window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hi_cnt <= 4'hF;
    else if (!sync_n) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else busy_cnt <= fuse_busy ? busy_cnt + 1 : 0;
  end
  assign in_win = (hi_cnt >= 4'h1) && (hi_cnt <= 4'hE);
  sequence busy_run;
    fuse_busy [*8];
  endsequence
  reset_values_a: assert property (
    $rose(rst_n) |-> wiper_position == 10'h200 && !shutdown && !calibration_bypass && !fuse_busy)
    else $error("output not at reset value");
  wiper_window_a: assert property (
    $changed(wiper_position) |-> in_win) else $error("wiper moved outside decode");
  ctrl_window_a: assert property (
    $changed(shutdown) || $changed(calibration_bypass) |-> in_win) else $error("control moved outside decode");
  busy_start_a: assert property (
    $rose(fuse_busy) |-> in_win) else $error("store began outside decode");
  busy_min_a: assert property (
    $rose(fuse_busy) |-> busy_run) else $error("store too short");
  frozen_a: assert property (
    fuse_busy |-> $stable(wiper_position) && $stable(shutdown) && $stable(calibration_bypass))
    else $error("state changed during store");
  store_len_a: assert property (
    $fell(fuse_busy) |-> busy_cnt >= STORE_CYCLES - 2 && busy_cnt <= STORE_CYCLES + 2)
    else $error("store length wrong");
  sout_window_a: assert property (
    $changed(serial_out) && !sync_n |-> sclk) else $error("serial out moved off rising clock");
endmodule : rcd_checker
bind rcd_core rcd_checker #(.STORE_CYCLES(STORE_CYCLES)) rcd_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .sync_n(sync_n), .sclk(sclk), .serial_out(serial_out), .wiper_position(wiper_position), .shutdown(shutdown),
  .calibration_bypass(calibration_bypass), .fuse_busy(fuse_busy));

// ### tb/rcd_host_model.sv
`timescale 1ns/1ns
module rcd_host_model (
  output logic sync_n,
  output logic sclk,
  output logic din,
  input wire logic serial_out
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // serial clock idles low and stands still between frames
  task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    sync_n = 1'b0;
    #63;
    for (int i = nbits - 1; i >= 0; i--) begin
      // data moves on the rising edge so it is settled well before the falling sample edge
      #62 sclk = 1'b1;
      din = w[i % 16];
      #63 rd = {rd[14:0], serial_out};
      sclk = 1'b0;
    end
    #63 sync_n = 1'b1;
    din = ~din;
    #200;
  endtask : frame
endmodule : rcd_host_model

// ### tb/rheostat_command_decoder_tb.sv
`timescale 1ns/1ns
module rheostat_command_decoder_tb;
  localparam int STORE_N = 400;
  logic core_clk;
  logic rst_n;
  logic sync_n;
  logic sclk;
  logic din;
  logic serial_out;
  logic [9:0] wiper_position;
  logic shutdown;
  logic calibration_bypass;
  logic fuse_busy;
  logic [15:0] rd;
  logic [15:0] st;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  assign st = {calibration_bypass, shutdown, fuse_busy, 3'h0, wiper_position};
  rcd_core #(.STORE_CYCLES(STORE_N)) rcd_core_inst (.core_clk(core_clk), .rst_n(rst_n), .sync_n(sync_n),
    .sclk(sclk), .din(din), .serial_out(serial_out), .wiper_position(wiper_position), .shutdown(shutdown),
    .calibration_bypass(calibration_bypass), .fuse_busy(fuse_busy));
  rcd_host_model rcd_host_model_inst (.sync_n(sync_n), .sclk(sclk), .din(din), .serial_out(serial_out));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // hang guard: the full run needs roughly 45000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [3:0] c, input logic [9:0] d);
    rcd_host_model_inst.frame({2'b00, c, d}, 16, rd);
  endtask : cmd
  task automatic rd_back(input logic [3:0] c, input logic [9:0] d, input logic [15:0] exp);
    cmd(c, d);
    cmd(4'h0, 10'h000);
    check(rd, exp);
  endtask : rd_back
  task automatic wait_store();
    for (int i = 0; i < 2 * STORE_N && fuse_busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : wait_store
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check(st, 16'h0200);
    rd_back(4'h8, 10'h000, 16'h0000);
    cmd(4'h1, 10'h155);
    cmd(4'h3, 10'h000);
    check(st, 16'h0200);
    cmd(4'h7, 10'h3FE);
    check(st, 16'h8200);
    rd_back(4'h8, 10'h000, 16'h0006);
    cmd(4'h1, 10'h000);
    check(st, 16'h8000);
    cmd(4'h1, 10'h155);
    rd_back(4'h2, 10'h000, 16'h0155);
    cmd(4'h3, 10'h000);
    rd_back(4'h6, 10'h000, 16'h0000);
    cmd(4'h7, 10'h003);
    cmd(4'h3, 10'h000);
    check(st, 16'h2155);
    cmd(4'h1, 10'h0AA);
    wait_store();
    check(st, 16'h0155);
    rd_back(4'h8, 10'h000, 16'h000B);
    rd_back(4'h6, 10'h000, 16'h0001);
    rd_back(4'h5, 10'h3C1, 16'h0155);
    cmd(4'h1, 10'h2AA);
    cmd(4'h9, 10'h001);
    check(st, 16'h42AA);
    cmd(4'h9, 10'h3FE);
    check(st, 16'h02AA);
    for (int c = 10; c < 16; c++) cmd(4'(c), 10'h3FF);
    check(st, 16'h02AA);
    rcd_host_model_inst.frame({6'h01, 10'h0F0}, 17, rd);
    check(st, 16'h02AA);
    cmd(4'h1, 10'h000);
    cmd(4'h9, 10'h001);
    cmd(4'h4, 10'h3FF);
    check(st, 16'h0155);
    // the last pass tries a store beyond the final location
    for (int n = 2; n <= 51; n++) begin
      cmd(4'h3, 10'h000);
      wait_store();
    end
    rd_back(4'h6, 10'h000, 16'h0032);
    rd_back(4'h5, 10'h000, 16'h0000);
    test_done();
  end
endmodule : rheostat_command_decoder_tb
